// ===== hdl/lpc_pkg.sv
// constants for the led pwm channel register bank
// assumes a single 250 MHz clock domain and an i2c write-only host
package lpc_pkg;
    // ************************************************************
    // geometry
    // ************************************************************
    localparam int NUM_CHAN = 36;
    localparam int ADDR_W = 7;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] OFF_SHUTDOWN = 8'h00;
    localparam logic [7:0] OFF_DUTY_FIRST = 8'h01;
    localparam logic [7:0] OFF_DUTY_LAST = 8'h24;
    localparam logic [7:0] OFF_LOAD = 8'h25;
    localparam logic [7:0] OFF_CTRL_FIRST = 8'h26;
    localparam logic [7:0] OFF_CTRL_LAST = 8'h49;
    localparam logic [7:0] OFF_GLOBAL = 8'h4A;
    localparam logic [7:0] OFF_RESET = 8'h4F;
    // ************************************************************
    // values and fields
    // ************************************************************
    localparam logic [7:0] TRIGGER_VAL = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] DEV_ADDR_HI = 5'h0F;
    localparam int BIT_ON = 0;
    localparam int SCALE_LO = 1;
    localparam int SCALE_HI = 2;
    localparam int BIT_SOFT_RUN = 0;
    localparam int BIT_GDIS = 0;
    localparam int PWM_W = 8;
    // ************************************************************
    // current scale encodings
    // ************************************************************
    localparam logic [1:0] SCALE_FULL = 2'h0;
    localparam logic [1:0] SCALE_HALF = 2'h1;
    localparam logic [1:0] SCALE_THIRD = 2'h2;
    localparam logic [1:0] SCALE_QUARTER = 2'h3;
    // ************************************************************
    // serial receiver states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_DATA = 3'b011,
        ST_DACK = 3'b100,
        ST_SKIP = 3'b101
    } lpc_state_e;
endpackage : lpc_pkg

// ===== hdl/lpc_byte_bank.sv
// byte-wide register memory with registered read port
// assumes one clock; clear wipes every entry in one cycle
module lpc_byte_bank #(
    parameter int DEPTH = 36
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic clear,
    input wire logic wrEn,
    input wire logic [7:0] wrIdx,
    input wire logic [7:0] wrData,
    // all entries, registered
    output logic [DEPTH*8-1:0] rdAll
);
    // ************************************************************
    // storage
    // ************************************************************
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gEntry
            // each entry resets or clears to zero, else takes its write
            always_ff @(posedge clk) begin
                if (!rstn || clear) begin
                    rdAll[g*8 +: 8] <= lpc_pkg::RST_BYTE;
                end else if (wrEn && wrIdx == 8'(g)) begin
                    rdAll[g*8 +: 8] <= wrData;
                end
            end
        end
    endgenerate
endmodule : lpc_byte_bank

// ===== hdl/lpc_channel_regs.sv
// i2c write-only register bank driving 36 pwm led channels
// assumes scl/sda/ad/hw_shutdown_n come from outside and are synchronised
// Function
// RULE1: duty and control writes go to shadows; writing 00h to 25h loads them
// RULE2: control bits 2:1 pick current full, half, third or quarter
// RULE3: control bit 0 turns channel on; upper bits unused; default zero
// RULE4: global register bit 0 set forces every led off
// RULE5: writing 00h to reset register returns all registers to defaults
// RULE6: after reset every register is at default and outputs dark
// RULE7: thirty-six eight-bit duty registers, value k gives step k
// RULE8: shutdown of either kind leaves register contents untouched
// RULE9: shutdown bit 0 low turns all current sources off
// RULE10: hardware shutdown lasts while the active-low input is low
// RULE11: control registers map one per channel in ascending order
// RULE12: answer only writes to address 01111 plus two select bits
// RULE13: register pointer advances by one after each acknowledged byte
// RULE14: average current is scale times duty over 256
// RULE15: pwm period 256 ticks; output high for duty ticks, zero stays off
// RULE16: output drives only when on, not disabled, not shut down
module lpc_channel_regs #(
    parameter int NUM_CHAN = lpc_pkg::NUM_CHAN
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // serial port, sda open drain
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic [1:0] addrSel,
    // shutdown pin
    input wire logic hw_shutdown_n,
    // led outputs
    output logic [NUM_CHAN-1:0] ledOn,
    output logic [NUM_CHAN*2-1:0] current_scale
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [1:0] sclS_ff, sdaS_ff, hwRunS_ff;
    logic [1:0] adS0_ff, adS1_ff;
    logic sclD_ff, sdaD_ff;
    // two flops per pin plus a delay flop on scl and sda; logic reads stage 1 and the delay flops
    always_ff @(posedge clk) begin
        if (!rstn) begin
            sclS_ff <= 2'h3;
            sdaS_ff <= 2'h3;
            hwRunS_ff <= 2'h0;
            adS0_ff <= 2'h0;
            adS1_ff <= 2'h0;
            sclD_ff <= 1'b1;
            sdaD_ff <= 1'b1;
        end else begin
            sclS_ff <= {sclS_ff[0], scl};
            sdaS_ff <= {sdaS_ff[0], sdaIn};
            hwRunS_ff <= {hwRunS_ff[0], hw_shutdown_n};
            adS0_ff <= {adS0_ff[0], addrSel[0]};
            adS1_ff <= {adS1_ff[0], addrSel[1]};
            sclD_ff <= sclS_ff[1];
            sdaD_ff <= sdaS_ff[1];
        end
    end
    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise = sclS_ff[1] && !sclD_ff;
    assign sclFall = !sclS_ff[1] && sclD_ff;
    assign startCond = sclS_ff[1] && sclD_ff && sdaD_ff && !sdaS_ff[1];
    assign stopCond = sclS_ff[1] && sclD_ff && !sdaD_ff && sdaS_ff[1];
    // ************************************************************
    // serial receiver
    // ************************************************************
    lpc_pkg::lpc_state_e state_ff;
    logic [7:0] shift_ff;
    logic [3:0] bitCnt_ff;
    logic firstByte_ff;
    logic [7:0] ptr_ff;
    logic wrStb;
    logic [7:0] rxByte;
    logic addrHit;
    assign rxByte = {shift_ff[6:0], sdaS_ff[1]};
    // judged at the fall after bit 8, when the shifter holds the whole byte
    assign addrHit = shift_ff == {lpc_pkg::DEV_ADDR_HI,
        adS1_ff[1], adS0_ff[1], 1'b0}; // see RULE12
    // byte is complete on eighth rising edge of a data phase
    assign wrStb = state_ff == lpc_pkg::ST_DATA && sclRise
        && bitCnt_ff == 4'h7 && !firstByte_ff;
    // protocol walk: bits sampled on rising scl, ack driven after fall
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_ff <= lpc_pkg::ST_IDLE;
            shift_ff <= 8'h00;
            bitCnt_ff <= 4'h0;
            firstByte_ff <= 1'b1;
            ptr_ff <= 8'h00;
        end else if (startCond) begin
            state_ff <= lpc_pkg::ST_ADDR;
            bitCnt_ff <= 4'h0;
        end else if (stopCond) begin
            state_ff <= lpc_pkg::ST_IDLE;
        end else begin
            case (state_ff)
                lpc_pkg::ST_ADDR, lpc_pkg::ST_DATA: begin
                    if (sclRise) begin
                        shift_ff <= rxByte;
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                    end else if (sclFall && bitCnt_ff == 4'h8) begin
                        bitCnt_ff <= 4'h0;
                        if (state_ff == lpc_pkg::ST_ADDR) begin
                            // reads and foreign addresses are ignored
                            state_ff <= addrHit ? lpc_pkg::ST_AACK
                                : lpc_pkg::ST_SKIP; // see RULE12
                            firstByte_ff <= 1'b1;
                        end else begin
                            state_ff <= lpc_pkg::ST_DACK;
                            if (firstByte_ff) begin
                                ptr_ff <= shift_ff;
                            end
                        end
                    end
                end
                lpc_pkg::ST_AACK: begin
                    if (sclFall) begin
                        state_ff <= lpc_pkg::ST_DATA;
                    end
                end
                lpc_pkg::ST_DACK: begin
                    if (sclFall) begin
                        state_ff <= lpc_pkg::ST_DATA;
                        // pointer set by first byte, then steps per byte
                        if (!firstByte_ff) begin
                            ptr_ff <= ptr_ff + 8'h01; // see RULE13
                        end
                        firstByte_ff <= 1'b0;
                    end
                end
                lpc_pkg::ST_SKIP, lpc_pkg::ST_IDLE: begin
                    state_ff <= state_ff;
                end
                default: begin
                    state_ff <= lpc_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // ack pulls sda low; output value always low, enable gates it
    assign sdaOut = 1'b0;
    assign sdaOe = state_ff == lpc_pkg::ST_AACK
        || state_ff == lpc_pkg::ST_DACK;
    // ************************************************************
    // register decode
    // ************************************************************
    logic [7:0] wrAddr;
    logic softReset, loadLive;
    logic dutyWr, ctrlWr;
    assign wrAddr = ptr_ff;
    // 00h written to reset register wipes every register of the bank
    assign softReset = wrStb && wrAddr == lpc_pkg::OFF_RESET
        && rxByte == lpc_pkg::TRIGGER_VAL; // see RULE5
    assign loadLive = wrStb && wrAddr == lpc_pkg::OFF_LOAD
        && rxByte == lpc_pkg::TRIGGER_VAL; // see RULE1
    assign dutyWr = wrStb && wrAddr >= lpc_pkg::OFF_DUTY_FIRST
        && wrAddr <= lpc_pkg::OFF_DUTY_LAST;
    assign ctrlWr = wrStb && wrAddr >= lpc_pkg::OFF_CTRL_FIRST
        && wrAddr <= lpc_pkg::OFF_CTRL_LAST;
    // ************************************************************
    // scalar registers
    // ************************************************************
    logic softRun_ff, gdis_ff;
    // shutdown bits never touch other registers
    always_ff @(posedge clk) begin
        if (!rstn || softReset) begin
            softRun_ff <= 1'b0; // see RULE6
            gdis_ff <= 1'b0;
        end else if (wrStb && wrAddr == lpc_pkg::OFF_SHUTDOWN) begin
            softRun_ff <= rxByte[lpc_pkg::BIT_SOFT_RUN]; // see RULE9
        end else if (wrStb && wrAddr == lpc_pkg::OFF_GLOBAL) begin
            gdis_ff <= rxByte[lpc_pkg::BIT_GDIS]; // see RULE4
        end
    end
    // ************************************************************
    // shadow and live banks
    // ************************************************************
    logic [NUM_CHAN*8-1:0] shDuty, shCtrl;
    logic [NUM_CHAN*8-1:0] liveDuty_ff, liveCtrl_ff;
    // shadows in the memory module; index maps ascending channel
    lpc_byte_bank #(.DEPTH(NUM_CHAN)) uDutyShadow (
        .clk(clk),
        .rstn(rstn),
        .clear(softReset),
        .wrEn(dutyWr),
        .wrIdx(wrAddr - lpc_pkg::OFF_DUTY_FIRST), // see RULE7
        .wrData(rxByte),
        .rdAll(shDuty)
    );
    lpc_byte_bank #(.DEPTH(NUM_CHAN)) uCtrlShadow (
        .clk(clk),
        .rstn(rstn),
        .clear(softReset),
        .wrEn(ctrlWr),
        .wrIdx(wrAddr - lpc_pkg::OFF_CTRL_FIRST), // see RULE11
        .wrData(rxByte),
        .rdAll(shCtrl)
    );
    // live copies change only on the load trigger or a soft reset
    always_ff @(posedge clk) begin
        if (!rstn || softReset) begin
            liveDuty_ff <= '0;
            liveCtrl_ff <= '0;
        end else if (loadLive) begin
            liveDuty_ff <= shDuty; // see RULE1
            liveCtrl_ff <= shCtrl;
        end
    end
    // ************************************************************
    // pwm generation
    // ************************************************************
    logic [lpc_pkg::PWM_W-1:0] tick_ff;
    logic runOk;
    // free 256-tick period, one tick per clock
    always_ff @(posedge clk) begin
        if (!rstn) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= tick_ff + 1'b1; // see RULE15
        end
    end
    // shutdown only gates outputs, registers keep their data
    assign runOk = softRun_ff && !gdis_ff && hwRunS_ff[1]; // see RULE8
    genvar c;
    generate
        for (c = 0; c < NUM_CHAN; c++) begin : gChan
            // high for duty ticks of 256: mean = scale*duty/256
            always_ff @(posedge clk) begin
                if (!rstn) begin
                    ledOn[c] <= 1'b0;
                    current_scale[c*2 +: 2] <= lpc_pkg::SCALE_FULL;
                end else begin
                    ledOn[c] <= runOk
                        && liveCtrl_ff[c*8+lpc_pkg::BIT_ON] // see RULE3
                        && tick_ff < liveDuty_ff[c*8 +: 8]; // see RULE14
                    current_scale[c*2 +: 2] <= liveCtrl_ff[c*8
                        +lpc_pkg::SCALE_LO +: 2]; // see RULE2
                end
            end
        end
    endgenerate
    // ************************************************************
    // checks
    // ************************************************************
    a_hw_off: assert property (@(posedge clk) disable iff (!rstn)
        !hwRunS_ff[1] |=> ledOn == '0) // see RULE10
        else $error("led on during hardware shutdown");
    a_soft_off: assert property (@(posedge clk) disable iff (!rstn)
        (!softRun_ff || gdis_ff) |=> ledOn == '0) // see RULE16 RULE9
        else $error("led on during soft shutdown or disable");
    a_load_live: assert property (@(posedge clk) disable iff (!rstn)
        (loadLive && !softReset) |=> liveDuty_ff == $past(shDuty)) // see RULE1
        else $error("live duty not loaded");
    a_live_hold: assert property (@(posedge clk) disable iff (!rstn)
        (!loadLive && !softReset) |=> $stable(liveCtrl_ff)) // see RULE1
        else $error("live control changed without load");
    a_soft_reset: assert property (@(posedge clk) disable iff (!rstn)
        softReset |=> !softRun_ff && liveDuty_ff == '0 && shCtrl == '0) // see RULE5
        else $error("soft reset incomplete");
    a_ptr_step: assert property (@(posedge clk) disable iff (!rstn)
        (state_ff == lpc_pkg::ST_DACK && sclFall && !firstByte_ff
        && !startCond && !stopCond) |=> ptr_ff == $past(ptr_ff) + 8'h01) // see RULE13
        else $error("pointer did not step");
    a_ack_match: assert property (@(posedge clk) disable iff (!rstn)
        (state_ff == lpc_pkg::ST_ADDR && sclFall && bitCnt_ff == 4'h8
        && !addrHit && !startCond && !stopCond) |=> !sdaOe) // see RULE12
        else $error("acked foreign address");
    a_zero_duty: assert property (@(posedge clk) disable iff (!rstn)
        liveDuty_ff[7:0] == 8'h00 |=> !ledOn[0]) // see RULE15
        else $error("zero duty channel lit");
    a_scale_map: assert property (@(posedge clk) disable iff (!rstn)
        1'b1 |=> current_scale[1:0] == $past(liveCtrl_ff[2:1])) // see RULE2
        else $error("scale not from control bits");
endmodule : lpc_channel_regs

// ===== verification/lpc_i2c_master.sv
// i2c master model that writes register bytes into the led channel bank
// assumes sda is an open-drain wire with a pull-up built by the bench
module lpc_i2c_master (
    // clock
    input wire logic clk,
    // serial link
    output logic scl,
    output logic sdaLow,
    input wire logic sdaWire
);
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // bus idle level
    // ************************************************************
    // scl high and sda released while no frame runs
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end

    // wait n clock edges; scl half period is 8 clocks, 64 ns per bit
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // one bit: data set mid-low and held over the whole high phase
    task automatic put_bit(input logic b, output logic seen);
        sdaLow <= ~b;
        tick(4);
        scl <= 1'b1;
        tick(4);
        seen = sdaWire; // sampled mid-high, well after the ack settles
        tick(4);
        scl <= 1'b0;
        tick(4);
    endtask : put_bit

    // ************************************************************
    // whole write frame
    // ************************************************************
    // start, device byte, pointer, data, stop; aborts after any nack
    task automatic xfer(input logic [7:0] dev, input logic [7:0] ptr,
                        input logic [7:0] data[$], output logic allAck);
        logic [7:0] bytes[$];
        logic seen;
        bytes = data;
        bytes.push_front(ptr);
        bytes.push_front(dev); // caller sets bit 0; low except for the read in t_refuse
        allAck = 1'b1;
        sdaLow <= 1'b1;
        tick(8);
        scl <= 1'b0;
        tick(4);
        foreach (bytes[k]) begin
            for (int i = 7; i >= 0; i--) begin
                put_bit(bytes[k][i], seen);
            end
            put_bit(1'b1, seen); // release sda for the ack bit
            if (seen) begin
                allAck = 1'b0;
                break;
            end
        end
        // stop: sda rises while scl is high, then the bus rests
        sdaLow <= 1'b1;
        tick(4);
        scl <= 1'b1;
        tick(8);
        sdaLow <= 1'b0;
        tick(8);
    endtask : xfer
endmodule : lpc_i2c_master

// ===== verification/tb_top.sv
// self-checking bench for the led channel register bank
// assumes the i2c master model drives the link and sda has a pull-up
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NC = lpc_pkg::NUM_CHAN;
    localparam logic [7:0] DEV = {lpc_pkg::DEV_ADDR_HI, 2'b10, 1'b0};
    logic clk, rstn, scl, sdaLow, sdaOut, sdaOe, hwShutdownN, sdaWire;
    logic [NC-1:0] ledOn;
    logic [NC*2-1:0] scaleOut;
    int miscompares, tests_run;

    // ************************************************************
    // wiring and clock
    // ************************************************************
    // open-drain wire: low if either side pulls, pull-up otherwise
    assign sdaWire = ~(sdaLow | (sdaOe & ~sdaOut));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    lpc_channel_regs u_dut (
        .clk(clk), .rstn(rstn), .scl(scl), .sdaIn(sdaWire),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSel(2'b10),
        .hw_shutdown_n(hwShutdownN), .ledOn(ledOn),
        .current_scale(scaleOut));
    lpc_i2c_master u_host (
        .clk(clk), .scl(scl), .sdaLow(sdaLow), .sdaWire(sdaWire));

    // ************************************************************
    // compare and access helpers
    // ************************************************************
    task automatic chk_val(input logic [71:0] got, input logic [71:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t value %0h expected %0h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_ack(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t ack %b expected %b", $time, got, exp);
        end
    endtask : chk_ack
    // counts high clocks of one channel over one full pwm period
    task automatic chk_duty(input int c, input logic [71:0] exp);
        logic [71:0] n;
        n = '0;
        repeat (256) begin
            @(negedge clk);
            n += ledOn[c];
        end
        // back on the rising edge so later stimulus launches there
        @(posedge clk);
        chk_val(n, exp);
    endtask : chk_duty
    task automatic wr(input logic [7:0] ptr, input logic [7:0] d[$]);
        logic ack;
        u_host.xfer(DEV, ptr, d, ack);
        chk_ack(ack, 1'b1);
    endtask : wr

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_defaults;
        chk_val(ledOn, '0);
        chk_val(scaleOut, '0);
    endtask : t_defaults
    // shadows hold until the load trigger; every scale code once
    task automatic t_shadow;
        logic [71:0] exp;
        wr(8'h00, '{8'h01});
        wr(8'h01, '{8'h80, 8'h05});
        wr(8'h26, '{8'h03, 8'h05});
        wr(8'h48, '{8'h07, 8'hF9});
        chk_val(scaleOut, '0);
        chk_duty(0, 72'd0);
        wr(8'h25, '{8'h00});
        exp = '0;
        exp[1:0] = 2'b01;
        exp[3:2] = 2'b10;
        exp[69:68] = 2'b11;
        chk_val(scaleOut, exp);
        chk_duty(0, 72'd128);
        chk_duty(1, 72'd5);
        chk_duty(34, 72'd0);
        chk_duty(35, 72'd0);
    endtask : t_shadow
    // each gate darkens the channel and keeps its registers intact
    task automatic t_gates;
        wr(8'h4A, '{8'h01});
        chk_duty(0, 72'd0);
        wr(8'h4A, '{8'h00});
        chk_duty(0, 72'd128);
        wr(8'h00, '{8'h00});
        chk_duty(0, 72'd0);
        wr(8'h00, '{8'h01});
        chk_duty(0, 72'd128);
        hwShutdownN <= 1'b0;
        repeat (8) @(posedge clk);
        chk_duty(0, 72'd0);
        hwShutdownN <= 1'b1;
        repeat (8) @(posedge clk);
        chk_duty(0, 72'd128);
    endtask : t_gates
    // foreign address and read bit refused; nonzero trigger ignored
    task automatic t_refuse;
        logic ack;
        u_host.xfer({lpc_pkg::DEV_ADDR_HI, 3'b010}, 8'h01, '{8'h33}, ack);
        chk_ack(ack, 1'b0);
        u_host.xfer({lpc_pkg::DEV_ADDR_HI, 3'b101}, 8'h01, '{8'h33}, ack);
        chk_ack(ack, 1'b0);
        wr(8'h01, '{8'h10});
        wr(8'h25, '{8'h01});
        chk_duty(0, 72'd128);
        wr(8'h25, '{8'h00});
        chk_duty(0, 72'd16);
    endtask : t_refuse
    task automatic t_soft_reset;
        wr(8'h4F, '{8'h00});
        chk_val(ledOn, '0);
        chk_val(scaleOut, '0);
        wr(8'h00, '{8'h01});
        wr(8'h25, '{8'h00});
        chk_duty(0, 72'd0);
    endtask : t_soft_reset

    // ************************************************************
    // run control
    // ************************************************************
    task automatic final_report;
        if (miscompares == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        rstn = 1'b0;
        hwShutdownN = 1'b1;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_defaults();
        t_shadow();
        t_gates();
        t_refuse();
        t_soft_reset();
        final_report();
    end
    // whole run needs about 12 k clocks; cut off well beyond that
    initial begin
        #300000;
        miscompares++;
        final_report();
    end
endmodule : tb_top
